// >>> rtl/pms_pkg.sv
package pms_pkg;
    localparam int CLK_MHZ = 40;
    localparam int AW = 4;
    localparam int DW = 32;
    localparam int SW = 20;
    localparam int NCH = 3;
    localparam int AVG_MAX_LG = 10;
    localparam int ACC_W = SW + AVG_MAX_LG;
    localparam int ENE_W = 48;
    localparam int CHG_W = 40;
    localparam int CH_TEMP = 0;
    localparam int CH_CUR = 1;
    localparam int CH_BUS = 2;
    // Register indices
    localparam logic [3:0] A_CFG = 4'h0;
    localparam logic [3:0] A_ADC = 4'h1;
    localparam logic [3:0] A_TCOEF = 4'h2;
    localparam logic [3:0] A_CUR = 4'h3;
    localparam logic [3:0] A_BUS = 4'h4;
    localparam logic [3:0] A_TEMP = 4'h5;
    localparam logic [3:0] A_PWR = 4'h6;
    localparam logic [3:0] A_ENE = 4'h7;
    localparam logic [3:0] A_CHG = 4'h8;
    localparam logic [3:0] A_DIAG = 4'h9;
    // Field positions
    localparam int F_DLY = 0;
    localparam int F_AVG = 0;
    localparam int F_TCT = 3;
    localparam int F_SCT = 6;
    localparam int F_VCT = 9;
    localparam int F_MODE = 12;
    localparam int MODE_BUS_B = 0;
    localparam int MODE_CUR_B = 1;
    localparam int MODE_CONT_B = 3;
    // Reset values
    localparam logic [7:0] DLY_RST = 8'h00;
    localparam logic [15:0] ADC_CFG_RST = 16'hbb68;
    localparam logic [15:0] TCOEF_RST = 16'h0000;
    localparam int TC_SHIFT = 12;
    // Timing
    localparam int DLY_STEP_US = 2000;
    localparam int CT_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
    localparam int AVG_LG [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
    typedef enum {ST_OFF, ST_DLY, ST_TEMP, ST_SHUNT, ST_BUS} pms_state_e;
endpackage : pms_pkg

// >>> rtl/pms_acc_if.sv
`timescale 1ns/1ps
interface pms_acc_if;
    import pms_pkg::*;
    logic clr;
    logic [NCH-1:0] add;
    logic signed [SW-1:0] smp;
    logic signed [ACC_W-1:0] sum [NCH];
    modport seq (output clr, output add, output smp, input sum);
    modport acc (input clr, input add, input smp, output sum);
endinterface : pms_acc_if

// >>> rtl/pms_accum.sv
`timescale 1ns/1ps
module pms_accum (
    input logic mclk,
    input logic rst,
    pms_acc_if.acc a
);
    import pms_pkg::*;

    // One running sum per quantity
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic signed [ACC_W-1:0] sum;
        always_ff @(posedge mclk) begin
            if (rst) begin
                sum <= '0;
            end else if (a.clr) begin
                sum <= a.add[i] ? ACC_W'(a.smp) : '0;
            end else if (a.add[i]) begin
                sum <= sum + ACC_W'(a.smp);
            end
        end
        assign a.sum[i] = sum;
    end
endmodule : pms_accum

// >>> rtl/pms_delay.sv
`timescale 1ns/1ps
module pms_delay #(
    parameter int STEP_CYC = pms_pkg::DLY_STEP_US * pms_pkg::CLK_MHZ
) (
    input logic mclk,
    input logic rst,
    input logic start,
    input logic [7:0] steps,
    output logic done
);
    import pms_pkg::*;

    logic run;
    logic [7:0] steps_left;
    logic [31:0] tick;

    always_ff @(posedge mclk) begin
        if (rst) begin
            run <= 1'b0;
            steps_left <= 8'h00;
            tick <= 32'h0;
        end else if (start) begin
            run <= 1'b1;
            steps_left <= steps;
            tick <= 32'h0;
        end else if (run) begin
            if (steps_left == 8'h00) begin
                run <= 1'b0;
            end else if (tick == 32'(STEP_CYC - 1)) begin
                tick <= 32'h0;
                steps_left <= steps_left - 8'h01;
            end else begin
                tick <= tick + 32'h1;
            end
        end
    end

    assign done = run && steps_left == 8'h00;
endmodule : pms_delay

// >>> rtl/pms_top.sv
`timescale 1ns/1ps
module pms_top #(
    parameter int CT_SCALE = pms_pkg::CLK_MHZ,
    parameter int DLY_STEP_CYC = pms_pkg::DLY_STEP_US * pms_pkg::CLK_MHZ
) (
    input logic mclk,
    input logic rst,
    input logic [pms_pkg::AW-1:0] reg_addr,
    input logic [pms_pkg::DW-1:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [pms_pkg::DW-1:0] reg_rdata,
    input logic signed [pms_pkg::SW-1:0] adc_result,
    output logic [1:0] adc_chan,
    output logic [2:0] adc_ct_sel,
    output logic adc_restart,
    output logic adc_run,
    output logic conversion_ready_flag,
    output logic result_load
);
    import pms_pkg::*;

    pms_state_e st, next_st, first_st;
    logic [7:0] start_delay_field;
    logic [15:0] adc_cfg, tcoef;
    logic [17:0] ct_cnt, ct_lim;
    logic [10:0] avg_cnt;
    logic [3:0] mode, new_mode;
    logic [3:0] avg_lg;
    logic cfg_wr, diag_rd, boot, seq_start, dly_done, new_run;
    logic cur_en, bus_en, cont, run_ok, conv, next_conv;
    logic ct_end, pass_end, last_pass;
    logic fin1, fin2, ec1, ec2, acc_valid;
    logic signed [SW-1:0] temp_last, cur_last, bus_last, cur_comp;
    logic signed [SW+15:0] comp_prod;
    logic signed [SW-1:0] avg_t, avg_c, avg_b, res_temp, res_cur, res_bus;
    logic signed [2*SW-1:0] pw_inst, res_pwr;
    logic signed [ENE_W-1:0] energy;
    logic signed [CHG_W-1:0] charge;
    logic [DW-1:0] next_rdata;

    pms_acc_if acc ();

    function automatic logic [2:0] ct_of(input pms_state_e s, input logic [15:0] c);
        case (s)
            ST_TEMP: ct_of = c[F_TCT +: 3];
            ST_SHUNT: ct_of = c[F_SCT +: 3];
            default: ct_of = c[F_VCT +: 3];
        endcase
    endfunction : ct_of

    // Mode decode
    assign mode = adc_cfg[F_MODE +: 4];
    assign new_mode = reg_wdata[F_MODE +: 4];
    assign cur_en = mode[MODE_CUR_B];
    assign bus_en = mode[MODE_BUS_B];
    assign cont = mode[MODE_CONT_B];
    assign run_ok = cur_en | bus_en;
    assign new_run = new_mode[MODE_CUR_B] | new_mode[MODE_BUS_B];
    assign avg_lg = 4'(AVG_LG[adc_cfg[F_AVG +: 3]]);
    assign first_st = cur_en ? ST_TEMP : ST_BUS;

    // Register access strobes
    assign cfg_wr = reg_wr && reg_addr == A_ADC;
    assign diag_rd = reg_rd && reg_addr == A_DIAG;
    assign seq_start = cfg_wr ? new_run : (boot && run_ok);

    // Conversion timing
    assign conv = st == ST_TEMP || st == ST_SHUNT || st == ST_BUS;
    assign next_conv = next_st == ST_TEMP || next_st == ST_SHUNT || next_st == ST_BUS;
    assign ct_lim = 18'(CT_US[ct_of(st, adc_cfg)] * CT_SCALE);
    assign ct_end = conv && ct_cnt == ct_lim - 18'd1;
    assign pass_end = ct_end && (st == ST_BUS || (st == ST_SHUNT && !bus_en));
    assign last_pass = avg_cnt == 11'((1 << avg_lg) - 1);

    always_ff @(posedge mclk) begin
        if (rst) begin
            boot <= 1'b1;
        end else begin
            boot <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            start_delay_field <= DLY_RST;
            adc_cfg <= ADC_CFG_RST;
            tcoef <= TCOEF_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                A_CFG: start_delay_field <= reg_wdata[F_DLY +: 8];
                A_ADC: adc_cfg <= reg_wdata[15:0];
                A_TCOEF: tcoef <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    pms_delay #(
        .STEP_CYC(DLY_STEP_CYC)
    ) u_dly (
        .mclk(mclk),
        .rst(rst),
        .start(seq_start),
        .steps(start_delay_field),
        .done(dly_done)
    );

    // Sequencer
    always_comb begin
        next_st = st;
        if (seq_start) begin
            next_st = ST_DLY;
        end else if (cfg_wr) begin
            next_st = ST_OFF;
        end else begin
            case (st)
                ST_OFF: next_st = ST_OFF;
                ST_DLY: begin
                    if (dly_done) next_st = first_st;
                end
                ST_TEMP: begin
                    if (ct_end) next_st = ST_SHUNT;
                end
                ST_SHUNT, ST_BUS: begin
                    if (pass_end) begin
                        next_st = (last_pass && !cont) ? ST_OFF : first_st;
                    end else if (ct_end) begin
                        next_st = ST_BUS;
                    end
                end
                default: next_st = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= ST_OFF;
            adc_run <= 1'b0;
            adc_chan <= 2'(CH_BUS);
            adc_ct_sel <= 3'h0;
            adc_restart <= 1'b0;
        end else begin
            st <= next_st;
            adc_run <= next_conv;
            adc_chan <= next_st == ST_TEMP ? 2'(CH_TEMP) :
                        next_st == ST_SHUNT ? 2'(CH_CUR) : 2'(CH_BUS);
            adc_ct_sel <= ct_of(next_st, cfg_wr ? reg_wdata[15:0] : adc_cfg);
            adc_restart <= next_conv && (next_st != st || ct_end);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || !conv || ct_end || cfg_wr) begin
            ct_cnt <= 18'h0;
        end else begin
            ct_cnt <= ct_cnt + 18'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || seq_start) begin
            avg_cnt <= 11'h0;
        end else if (pass_end) begin
            avg_cnt <= last_pass ? 11'h0 : avg_cnt + 11'h1;
        end
    end

    // Sample capture with temperature compensation
    assign comp_prod = temp_last * $signed(tcoef);
    assign cur_comp = adc_result + SW'(comp_prod >>> TC_SHIFT);

    always_ff @(posedge mclk) begin
        if (rst) begin
            temp_last <= '0;
            cur_last <= '0;
            bus_last <= '0;
        end else if (ct_end && !cfg_wr) begin
            case (st)
                ST_TEMP: temp_last <= adc_result;
                ST_SHUNT: cur_last <= cur_comp;
                ST_BUS: bus_last <= adc_result;
                default: ;
            endcase
        end
    end

    assign acc.add = {st == ST_BUS, st == ST_SHUNT, st == ST_TEMP}
                     & {NCH{ct_end && !cfg_wr}};
    assign acc.smp = st == ST_SHUNT ? cur_comp : adc_result;
    assign acc.clr = fin1 || seq_start;

    pms_accum u_acc (
        .mclk(mclk),
        .rst(rst),
        .a(acc)
    );

    // Finishing pipeline runs while the next pass converts
    always_ff @(posedge mclk) begin
        if (rst) begin
            fin1 <= 1'b0;
            fin2 <= 1'b0;
            ec1 <= 1'b0;
            ec2 <= 1'b0;
        end else begin
            fin1 <= pass_end && last_pass && !cfg_wr;
            fin2 <= fin1;
            ec1 <= pass_end && !cfg_wr;
            ec2 <= ec1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            avg_t <= '0;
            avg_c <= '0;
            avg_b <= '0;
        end else if (fin1) begin
            avg_t <= SW'(acc.sum[CH_TEMP] >>> avg_lg);
            avg_c <= SW'(acc.sum[CH_CUR] >>> avg_lg);
            avg_b <= SW'(acc.sum[CH_BUS] >>> avg_lg);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            res_temp <= '0;
            res_cur <= '0;
            res_bus <= '0;
            res_pwr <= '0;
        end else if (fin2) begin
            if (cur_en) begin
                res_temp <= avg_t;
                res_cur <= avg_c;
            end
            if (bus_en) res_bus <= avg_b;
            if (cur_en && bus_en) res_pwr <= avg_c * avg_b;
        end
    end

    assign result_load = fin2;

    // Energy and charge, once per pass, never averaged
    always_ff @(posedge mclk) begin
        if (rst || seq_start) begin
            pw_inst <= '0;
            charge <= '0;
        end else if (ec1) begin
            pw_inst <= cur_last * bus_last;
            if (cur_en) charge <= charge + CHG_W'(cur_last);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || seq_start) begin
            energy <= '0;
        end else if (ec2 && cur_en && bus_en) begin
            energy <= energy + ENE_W'(pw_inst);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_valid <= 1'b0;
        end else if (seq_start) begin
            acc_valid <= cfg_wr ? new_mode[MODE_CONT_B] : cont;
        end else if (cfg_wr) begin
            acc_valid <= 1'b0;
        end
    end

    // Ready flag: a completion beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            conversion_ready_flag <= 1'b0;
        end else if (fin2) begin
            conversion_ready_flag <= 1'b1;
        end else if ((cfg_wr && new_run) || diag_rd) begin
            conversion_ready_flag <= 1'b0;
        end
    end

    // Read port
    always_comb begin
        case (reg_addr)
            A_CFG: next_rdata = DW'(start_delay_field);
            A_ADC: next_rdata = DW'(adc_cfg);
            A_TCOEF: next_rdata = DW'(tcoef);
            A_CUR: next_rdata = DW'(res_cur);
            A_BUS: next_rdata = DW'(res_bus);
            A_TEMP: next_rdata = DW'(res_temp);
            A_PWR: next_rdata = res_pwr[2*SW-1 -: DW];
            A_ENE: next_rdata = energy[ENE_W-1 -: DW];
            A_CHG: next_rdata = charge[CHG_W-1 -: DW];
            A_DIAG: next_rdata = DW'({acc_valid, conversion_ready_flag, adc_run});
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : '0;
        end
    end

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_rdy_set;
        fin2 |=> conversion_ready_flag;
    endproperty
    a_rdy_set: assert property (p_rdy_set) else $error("ready flag not set");

    property p_rdy_clr;
        ((cfg_wr && new_run) || diag_rd) && !fin2 |=> !conversion_ready_flag;
    endproperty
    a_rdy_clr: assert property (p_rdy_clr) else $error("ready flag not cleared");

    property p_hold;
        !fin2 |=> $stable(res_cur) && $stable(res_bus) && $stable(res_pwr);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed early");

    property p_abort;
        cfg_wr |=> $past(new_run) ? (st == ST_DLY && avg_cnt == 11'h0) : st == ST_OFF;
    endproperty
    a_abort: assert property (p_abort) else $error("mode write did not restart");

    property p_trig_off;
        pass_end && last_pass && !cont && !cfg_wr |=> st == ST_OFF ##1 !adc_run;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("single shot not stopped");

    property p_temp_first;
        $rose(st == ST_SHUNT) |-> $past(st) == ST_TEMP && $past(ct_end);
    endproperty
    a_temp_first: assert property (p_temp_first) else $error("shunt without temp");

    property p_avg_one;
        fin1 && avg_lg == 4'h0 && cur_en |=> avg_c == $past(cur_last);
    endproperty
    a_avg_one: assert property (p_avg_one) else $error("single average altered");

    property p_energy;
        !ec2 && !seq_start |=> $stable(energy);
    endproperty
    a_energy: assert property (p_energy) else $error("energy moved off pass");

    property p_no_gap;
        pass_end && !cfg_wr && (cont || !last_pass) |=> conv && adc_run;
    endproperty
    a_no_gap: assert property (p_no_gap) else $error("gap between passes");

    property p_no_delay;
        seq_start && start_delay_field == 8'h00 ##1 !cfg_wr |=> conv;
    endproperty
    a_no_delay: assert property (p_no_delay) else $error("zero delay not immediate");

    c_load: cover property (fin2 ##1 conversion_ready_flag);
    c_trig_done: cover property (pass_end && last_pass && !cont ##1 st == ST_OFF);
    c_diag_clr: cover property (conversion_ready_flag && diag_rd ##1 !conversion_ready_flag);
endmodule : pms_top

// >>> testbench/pms_top_tb.sv
`timescale 1ns/1ps
module pms_top_tb;
    import pms_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [AW-1:0] reg_addr = '0;
    logic [DW-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DW-1:0] reg_rdata;
    logic signed [SW-1:0] adc_result = '0;
    logic [1:0] adc_chan;
    logic [2:0] adc_ct_sel;
    logic adc_restart;
    logic adc_run;
    logic conversion_ready_flag;
    logic result_load;
    int failures = 0;
    int n_checks = 0;
    int seed = 32'haa39;
    int base [3];
    logic tog [3];
    logic [2:0] exp_ct [3];
    logic fresh = 1'b1;
    int cnt = 0;
    int k;
    logic [1:0] last_ch = 2'd0;
    logic [1:0] seq [$];
    logic [DW-1:0] d;
    logic [DW-1:0] hold;
    longint p;

    always #12.5 mclk = ~mclk;

    pms_top #(.CT_SCALE(1), .DLY_STEP_CYC(4)) u_pms_top (
        .mclk(mclk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .adc_result(adc_result),
        .adc_chan(adc_chan),
        .adc_ct_sel(adc_ct_sel),
        .adc_restart(adc_restart),
        .adc_run(adc_run),
        .conversion_ready_flag(conversion_ready_flag),
        .result_load(result_load)
    );

    task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Charge after four current passes: sum of compensated samples, never averaged
    function automatic logic [DW-1:0] exp_charge(input int t, input int c);
        return DW'((4 * (t + c) + 8) >>> 8);
    endfunction : exp_charge

    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // Mode write with new periods; sample pattern restarts
    task automatic setcfg(input logic [3:0] m, input logic [2:0] v, s, t, a);
        exp_ct[CH_BUS] = v;
        exp_ct[CH_CUR] = s;
        exp_ct[CH_TEMP] = t;
        for (int i = 0; i < 3; i++) begin
            tog[i] = 1'b0;
        end
        fresh = 1'b1;
        seq.delete();
        wr(A_ADC, {16'h0, m, v, s, t, a});
    endtask : setcfg

    task automatic wait_load(input int lim);
        k = 0;
        while (result_load !== 1'b1 && k < lim) begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk("result_load", k < lim, 1'b1);
    endtask : wait_load

    // Converter: each channel alternates base and base+2 per conversion
    always @(posedge mclk) begin
        if (adc_restart === 1'b1) begin
            tog[adc_chan] <= ~tog[adc_chan];
        end
        adc_result <= SW'(base[adc_chan] + (tog[adc_chan] ? 2 : 0));
    end

    // Conversion order, period select and length
    always @(posedge mclk) begin
        if (adc_restart === 1'b1) begin
            if (cnt > 0 && !fresh) begin
                chk("conv_len", cnt, CT_US[exp_ct[last_ch]]);
            end
            fresh <= 1'b0;
            seq.push_back(adc_chan);
            chk("ct_sel", adc_ct_sel, exp_ct[adc_chan]);
            cnt <= 1;
            last_ch <= adc_chan;
        end else if (adc_run === 1'b1) begin
            cnt <= cnt + 1;
        end else if (cnt > 0) begin
            // A conversion cut short by a mode write is not timed
            if (!fresh) begin
                chk("conv_len", cnt, CT_US[exp_ct[last_ch]]);
            end
            cnt <= 0;
        end
    end

    initial begin
        #2000000;
        failures++;
        $display("[FAIL] watchdog expected done seen timeout");
        report_and_stop();
    end

    initial begin
        for (int i = 0; i < 3; i++) begin
            base[i] = $random(seed) & 32'h3fff;
            tog[i] = 1'b0;
            exp_ct[i] = 3'd5;
        end
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd(A_CFG, d);
        chk("config", d, {24'h0, DLY_RST});
        rd(A_ADC, d);
        chk("adc_config", d, {16'h0, ADC_CFG_RST});
        rd(4'hf, d);
        chk("unmapped", d, 32'h0);
        rd(A_DIAG, d);
        chk("ready_rst", d[1], 1'b0);
        $display("test reset done");

        // Triggered bus only, one sample
        setcfg(4'h1, 3'd0, 3'd2, 3'd3, 3'd0);
        wait_load(200);
        rd(A_BUS, hold);
        chk("bus_single", hold, DW'(base[CH_BUS] + 2));
        chk("flag_set", conversion_ready_flag, 1'b1);
        chk("seq_n", seq.size(), 1);
        chk("seq_bus", seq[0], CH_BUS);
        setcfg(4'h0, 3'd0, 3'd2, 3'd3, 3'd0);
        repeat (100) @(posedge mclk);
        #1;
        chk("flag_shutdown", conversion_ready_flag, 1'b1);
        chk("run_off", adc_run, 1'b0);
        rd(A_BUS, d);
        chk("bus_hold", d, hold);
        rd(A_DIAG, d);
        chk("diag_flag", d[1], 1'b1);
        chk("diag_valid", d[2], 1'b0);
        @(posedge mclk);
        #1;
        chk("flag_diag_clr", conversion_ready_flag, 1'b0);
        $display("test triggered bus done");

        // Triggered current only, four samples, compensation one to one
        wr(A_TCOEF, 32'h1000);
        rd(A_TCOEF, d);
        chk("tcoef", d, 32'h1000);
        setcfg(4'h2, 3'd2, 3'd1, 3'd0, 3'd1);
        wait_load(2000);
        chk("cur_time", k >= 536 && k <= 541, 1'b1);
        rd(A_TEMP, d);
        chk("temp_avg", d, DW'(base[CH_TEMP] + 1));
        rd(A_CUR, d);
        chk("cur_avg", d, DW'(base[CH_TEMP] + base[CH_CUR] + 2));
        rd(A_CHG, d);
        chk("charge", d, exp_charge(base[CH_TEMP], base[CH_CUR]));
        chk("seq_n", seq.size(), 8);
        for (int i = 0; i < 8; i++) begin
            chk("seq_cur", seq[i], i % 2);
        end
        $display("test current done");

        // Continuous current and bus with power
        setcfg(4'hb, 3'd0, 3'd0, 3'd0, 3'd1);
        wait_load(1000);
        for (int i = 0; i < 3; i++) begin
            chk("seq_all", seq[i], i);
        end
        rd(A_PWR, d);
        p = longint'(base[CH_TEMP] + base[CH_CUR] + 2) * longint'(base[CH_BUS] + 1);
        chk("power", d, DW'(p >>> 8));
        rd(A_DIAG, d);
        chk("diag_valid", d[2], 1'b1);
        wait_load(1000);
        rd(A_BUS, d);
        chk("bus_avg", d, DW'(base[CH_BUS] + 1));
        chk("flag_cont", conversion_ready_flag, 1'b1);
        $display("test continuous done");

        // Abort with start delay of three steps
        wr(A_CFG, 32'h3);
        setcfg(4'hb, 3'd0, 3'd0, 3'd0, 3'd1);
        #1;
        k = 0;
        while (adc_restart !== 1'b1 && k < 50) begin
            chk("flag_write_clr", conversion_ready_flag, 1'b0);
            @(posedge mclk);
            #1;
            k++;
        end
        chk("delay_span", k >= 12 && k <= 15, 1'b1);
        chk("restart_temp", adc_chan, CH_TEMP);
        $display("test abort delay done");
        report_and_stop();
    end
endmodule : pms_top_tb
